/* File: verilog/bp_cfg.svh */
// constants for the bldc pwm block: offsets, fields, resets and timing
`ifndef BP_CFG_SVH
`define BP_CFG_SVH

// =====================================
// clock and timing
`define BP_CLK_HZ        200000000
`define BP_PWM_HZ        20000
`define BP_PERIOD_RST    (`BP_CLK_HZ / `BP_PWM_HZ)
`define BP_STEP_RST      24'h0007D0
`define BP_FILT0_NS      150
`define BP_FILT1_NS      450
`define BP_FILT2_NS      900
`define BP_FILT3_NS      1800
`define BP_CLK_PER_NS    5
`define BP_FILT0_CYC     (`BP_FILT0_NS / `BP_CLK_PER_NS)
`define BP_FILT1_CYC     (`BP_FILT1_NS / `BP_CLK_PER_NS)
`define BP_FILT2_CYC     (`BP_FILT2_NS / `BP_CLK_PER_NS)
`define BP_FILT3_CYC     (`BP_FILT3_NS / `BP_CLK_PER_NS)

// =====================================
// register word indices
`define BP_CTRL_IDX      5'h00
`define BP_PERIOD_IDX    5'h01
`define BP_DUTY_IDX      5'h02
`define BP_STEP_IDX      5'h03
`define BP_STAT_IDX      5'h04
`define BP_IEN_IDX       5'h05
`define BP_ICLR_IDX      5'h06
`define BP_IVEC_IDX      5'h07
`define BP_STATE_IDX     5'h08
`define BP_DCOMP_IDX     5'h09
`define BP_VAVG_IDX      5'h0A
`define BP_SAMP_BASE     5'h10

// =====================================
// control fields
`define BP_RUN_BIT       0
`define BP_CPON_BIT      1
`define BP_CFEN_BIT      2
`define BP_FSEL_LSB      3
`define BP_RSEL_LSB      5
`define BP_FEN_BIT       7
`define BP_XCEN_BIT      8
`define BP_ICEN_BIT      9
`define BP_CTRL_W        10
`define BP_CTRL_RST      10'h000

// =====================================
// event bits and channels
`define BP_EV_FAULT      0
`define BP_EV_XCLR       1
`define BP_EV_ICLR       2
`define BP_VBUS_CH       4'h0
`define BP_SENSE_CH      4'hE
`define BP_AVG_SHIFT     6

// reference codes for 1.5 V, 2.0 V, 2.5 V on a 3.3 V full scale
`define BP_REF_15        10'h1D1
`define BP_REF_20        10'h26C
`define BP_REF_25        10'h307

`endif

/* File: verilog/bp_pkg.sv */
// types shared by the bldc pwm block
package bp_pkg;

	// six commutation steps, gray coded from BP_S0 to BP_S5
	typedef enum logic [2:0] {
		BP_S0 = 3'b000,
		BP_S1 = 3'b001,
		BP_S2 = 3'b011,
		BP_S3 = 3'b010,
		BP_S4 = 3'b110,
		BP_S5 = 3'b111
	} bp_step_t;

	// interrupt vector codes
	typedef enum logic [3:0] {
		BP_IV_NONE  = 4'h0,
		BP_IV_FAULT = 4'h2,
		BP_IV_XCLR  = 4'h4,
		BP_IV_ICLR  = 4'h6
	} bp_ivec_t;

endpackage

/* File: verilog/bp_filter.sv */
// selectable-delay glitch filter for the comparator output
`timescale 1ns/10ps
`default_nettype none
module bp_filter
	import bp_pkg::*;
(
	input  wire logic       clock,     // system clock
	input  wire logic       rst,       // async reset
	input  wire logic       din,       // raw comparator level
	input  wire logic       en,        // filter on
	input  wire logic [1:0] sel,       // delay step
	output logic            dout       // filtered level
);
`include "bp_cfg.svh"

	logic [8:0] cnt_r;
	logic       dout_r;
	logic [8:0] lim;
	logic       differs;

	assign lim = (sel == 2'h0) ? 9'(`BP_FILT0_CYC) :
	             (sel == 2'h1) ? 9'(`BP_FILT1_CYC) :
	             (sel == 2'h2) ? 9'(`BP_FILT2_CYC) : 9'(`BP_FILT3_CYC);
	assign differs = din != dout_r;
	assign dout = dout_r;

	// with en high, output follows only after the input stands for the chosen delay
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r  <= 9'h000;
			dout_r <= 1'b0;
		end else if (!en) begin
			cnt_r  <= 9'h000;
			dout_r <= din;  // see RL9
		end else if (!differs) begin
			cnt_r  <= 9'h000;
		end else if (cnt_r >= lim - 9'h001) begin
			cnt_r  <= 9'h000;
			dout_r <= din;  // see RL9
		end else begin
			cnt_r  <= cnt_r + 9'h001;
		end
	end

endmodule
`default_nettype wire

/* File: verilog/bp_top.sv */
// bldc six-step pwm generator with bus ripple compensation and current limit
// Functional notes
// RL1: only upper switches get the high-frequency pwm from the inverter timer.
// RL2: lower switches are plain outputs toggling only at electrical rate.
// RL3: each lower switch stays on 120 degrees while paired upper switch is modulated.
// RL4: bus, windings, sense, pot and temperature come as 10-bit converter samples.
// RL5: applied duty is reference duty times average over instantaneous bus voltage.
// RL6: compensated duty clamps to the period; zero bus sample avoids the divide.
// RL7: comparator output high while sense input exceeds the reference.
// RL8: power-on bit enables comparator; off means output stays low.
// RL9: filter-enable bit routes output through a four-step delay filter; here only the fault input is filtered, not comparator_output.
// RL10: reference select picks one of three thresholds: 1.5, 2.0, 2.5 V.
// RL11: current sense enters non-inverting input through input channel fourteen.
// RL12: inverting input comes from the internal reference generator only.
// RL13: comparator drives event fault input one; high raises fault, blocks pwm.
// RL14: pwm resumes as soon as the fault input falls; no software needed.
// RL15: each event input has enable, interrupt enable and sticky flag.
// RL16: an interrupt vector names the event that caused the interrupt.
// RL17: internal and external clear signals, each enabled, restart the timer.
// RL18: event signals feed the compare outputs so faults change the pwm.
`timescale 1ns/10ps
`default_nettype none
module bp_top
	import bp_pkg::*;
(
	input  wire logic        clock,                     // 200 MHz system clock
	input  wire logic        rst,                       // async reset, high
	input  wire logic [4:0]  avs_address,               // word address
	input  wire logic        avs_read,                  // read request
	input  wire logic        avs_write,                 // write request
	input  wire logic [31:0] avs_writedata,             // write data
	output logic [31:0]      avs_readdata,              // read data
	output logic             avs_waitrequest,           // stall
	input  wire logic        adc_valid,                 // converter sample strobe
	input  wire logic [3:0]  adc_channel,               // converter channel
	input  wire logic [9:0]  adc_data,                  // 10-bit sample
	input  wire logic [9:0]  comparator_input_fourteen, // sense level at the pin
	input  wire logic        ext_clear_in,              // external clear pin
	output logic [2:0]       upper_gate,                // high-side pwm u,v,w
	output logic [2:0]       lower_gate,                // low-side gpio u,v,w
	output logic             comparator_output,         // comparator result
	output logic             irq                        // level interrupt
);
`include "bp_cfg.svh"

	// =====================================
	// decode functions
	function automatic logic [2:0] hi_of(input bp_step_t s);
		case (s)
			BP_S0, BP_S1: hi_of = 3'b001;
			BP_S2, BP_S3: hi_of = 3'b010;
			BP_S4, BP_S5: hi_of = 3'b100;
			default:      hi_of = 3'b000;
		endcase
	endfunction

	function automatic logic [2:0] lo_of(input bp_step_t s);
		case (s)
			BP_S5, BP_S0: lo_of = 3'b010;
			BP_S1, BP_S2: lo_of = 3'b100;
			BP_S3, BP_S4: lo_of = 3'b001;
			default:      lo_of = 3'b000;
		endcase
	endfunction

	// =====================================
	// registers
	logic [`BP_CTRL_W-1:0] ctrl_r;
	logic [15:0]           period_r;
	logic [15:0]           duty_r;
	logic [23:0]           steplen_r;
	logic [2:0]            flag_r;
	logic [2:0]            flag_nxt;
	logic [2:0]            ien_r;
	logic [9:0]            samp_r [0:15];
	logic                  ack_r;
	logic [31:0]           rdata_r;
	logic [9:0]            sense_m_r;
	logic [9:0]            sense_r;
	logic                  xclr_m_r;
	logic                  xclr_r;
	logic                  xclr_d_r;
	logic                  comp_r;
	logic                  fault_d_r;
	logic [15:0]           acc_r;
	logic [15:0]           dcomp_r;
	logic [15:0]           dsh_r;
	logic [15:0]           cnt_r;
	logic [23:0]           scnt_r;
	bp_step_t              step_r;
	bp_step_t              step_nxt;
	logic [2:0]            upper_r;
	logic [2:0]            lower_r;
	logic                  irq_r;

	// =====================================
	// bus decode
	wire        req      = avs_read | avs_write;
	wire        wr_ok    = avs_write & ack_r;
	wire        rd_cap   = avs_read & ~ack_r;
	wire        wr_ctrl  = wr_ok & (avs_address == `BP_CTRL_IDX);
	wire        wr_per   = wr_ok & (avs_address == `BP_PERIOD_IDX);
	wire        wr_duty  = wr_ok & (avs_address == `BP_DUTY_IDX);
	wire        wr_step  = wr_ok & (avs_address == `BP_STEP_IDX);
	wire        wr_ien   = wr_ok & (avs_address == `BP_IEN_IDX);
	wire        wr_iclr  = wr_ok & (avs_address == `BP_ICLR_IDX);

	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata    = rdata_r;

	// =====================================
	// control fields
	wire       run     = ctrl_r[`BP_RUN_BIT];
	wire       cmp_on  = ctrl_r[`BP_CPON_BIT];
	wire       filt_en = ctrl_r[`BP_CFEN_BIT];
	wire [1:0] filt_sl = ctrl_r[`BP_FSEL_LSB+1:`BP_FSEL_LSB];
	wire [1:0] ref_sl  = ctrl_r[`BP_RSEL_LSB+1:`BP_RSEL_LSB];
	wire       fev_en  = ctrl_r[`BP_FEN_BIT];
	wire       xc_en   = ctrl_r[`BP_XCEN_BIT];
	wire       ic_en   = ctrl_r[`BP_ICEN_BIT];

	// =====================================
	// comparator and event inputs
	wire [9:0] ref_code = (ref_sl == 2'h0) ? `BP_REF_15 :  // see RL10
	                      (ref_sl == 2'h1) ? `BP_REF_20 : `BP_REF_25;  // see RL12
	wire       cmp_raw  = cmp_on & (sense_r > ref_code);  // see RL7, see RL8, see RL11
	wire       fault_in;
	wire       fault_act = fev_en & fault_in;             // see RL13
	wire       fault_rise = fault_act & ~fault_d_r;
	wire       xclr_rise = xc_en & xclr_r & ~xclr_d_r;    // see RL17
	wire       step_tick;
	wire       iclr_evt  = ic_en & step_tick;             // see RL17
	wire       tmr_clear = xclr_rise | iclr_evt;

	bp_filter bp_filter_i (
		.clock (clock),
		.rst   (rst),
		.din   (comp_r),
		.en    (filt_en),
		.sel   (filt_sl),
		.dout  (fault_in)
	);

	assign comparator_output = comp_r;

	// =====================================
	// interrupt flags and vector
	wire [2:0] ev_set = {iclr_evt, xclr_rise, fault_rise};  // see RL15
	wire [2:0] ev_clr = wr_iclr ? avs_writedata[2:0] : 3'h0;
	wire [2:0] pend   = flag_r & ien_r;
	bp_ivec_t  ivec;

	assign flag_nxt = (flag_r & ~ev_clr) | ev_set;  // set wins over clear
	assign ivec = pend[`BP_EV_FAULT] ? BP_IV_FAULT :  // see RL16
	              pend[`BP_EV_XCLR]  ? BP_IV_XCLR  :
	              pend[`BP_EV_ICLR]  ? BP_IV_ICLR  : BP_IV_NONE;
	assign irq = irq_r;

	// =====================================
	// ripple compensation
	wire [9:0]  vbus_now = samp_r[`BP_VBUS_CH];
	wire [9:0]  vbus_avg = acc_r[15:`BP_AVG_SHIFT];
	wire [25:0] d_prod   = duty_r * vbus_avg;
	wire [25:0] d_quot   = (vbus_now == 10'h000) ? {10'h000, duty_r} :  // see RL6
	                       d_prod / {16'h0000, vbus_now};                // see RL5
	wire [15:0] d_clamp  = (d_quot > {10'h000, period_r}) ? period_r : d_quot[15:0];  // see RL6
	wire [15:0] acc_nxt  = acc_r - (acc_r >> `BP_AVG_SHIFT) + {6'h00, adc_data};

	// =====================================
	// pwm timer and commutation
	wire        wrap     = cnt_r >= period_r - 16'h0001;
	wire        pwm_raw  = cnt_r < dsh_r;
	wire [2:0]  hi_sel   = hi_of(step_r);
	wire [2:0]  lo_sel   = lo_of(step_r);
	wire [2:0]  up_nxt;

	assign step_tick = run & (scnt_r >= steplen_r - 24'h000001);

	always_comb begin
		case (step_r)
			BP_S0:   step_nxt = BP_S1;
			BP_S1:   step_nxt = BP_S2;
			BP_S2:   step_nxt = BP_S3;
			BP_S3:   step_nxt = BP_S4;
			BP_S4:   step_nxt = BP_S5;
			BP_S5:   step_nxt = BP_S0;
			default: step_nxt = BP_S0;
		endcase
	end

	// per-phase compare output, forced low by the fault feedback
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ph
			assign up_nxt[g] = run & hi_sel[g] & pwm_raw & ~fault_act;  // see RL1, see RL14, see RL18
		end
	endgenerate

	assign upper_gate = upper_r;
	assign lower_gate = lower_r;

	// =====================================
	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (avs_address == `BP_CTRL_IDX) begin
			rd_mux = {22'h000000, ctrl_r};
		end else if (avs_address == `BP_PERIOD_IDX) begin
			rd_mux = {16'h0000, period_r};
		end else if (avs_address == `BP_DUTY_IDX) begin
			rd_mux = {16'h0000, duty_r};
		end else if (avs_address == `BP_STEP_IDX) begin
			rd_mux = {8'h00, steplen_r};
		end else if (avs_address == `BP_STAT_IDX) begin
			rd_mux = {29'h00000000, flag_r};
		end else if (avs_address == `BP_IEN_IDX) begin
			rd_mux = {29'h00000000, ien_r};
		end else if (avs_address == `BP_IVEC_IDX) begin
			rd_mux = {28'h0000000, ivec};
		end else if (avs_address == `BP_STATE_IDX) begin
			rd_mux = {20'h00000, upper_r, lower_r, step_r, fault_act, fault_in, comp_r};
		end else if (avs_address == `BP_DCOMP_IDX) begin
			rd_mux = {16'h0000, dcomp_r};
		end else if (avs_address == `BP_VAVG_IDX) begin
			rd_mux = {22'h000000, vbus_avg};
		end else if (avs_address >= `BP_SAMP_BASE) begin
			rd_mux = {22'h000000, samp_r[avs_address[3:0]]};
		end
	end

	// =====================================
	// bus handshake
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= req & ~ack_r;
			if (rd_cap) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// =====================================
	// software registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_r    <= `BP_CTRL_RST;
			period_r  <= 16'(`BP_PERIOD_RST);
			duty_r    <= 16'h0000;
			steplen_r <= `BP_STEP_RST;
			ien_r     <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= avs_writedata[`BP_CTRL_W-1:0];
			end
			if (wr_per) begin
				period_r <= avs_writedata[15:0];
			end
			if (wr_duty) begin
				duty_r <= avs_writedata[15:0];
			end
			if (wr_step) begin
				steplen_r <= avs_writedata[23:0];
			end
			if (wr_ien) begin
				ien_r <= avs_writedata[2:0];
			end
		end
	end

	// =====================================
	// events and interrupt
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_r    <= 3'h0;
			irq_r     <= 1'b0;
			fault_d_r <= 1'b0;
			xclr_d_r  <= 1'b0;
		end else begin
			flag_r    <= flag_nxt;
			irq_r     <= |(flag_nxt & ien_r);
			fault_d_r <= fault_act;
			xclr_d_r  <= xclr_r;
		end
	end

	// =====================================
	// pin synchronisers and comparator
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sense_m_r <= 10'h000;
			sense_r   <= 10'h000;
			xclr_m_r  <= 1'b0;
			xclr_r    <= 1'b0;
			comp_r    <= 1'b0;
		end else begin
			sense_m_r <= comparator_input_fourteen;
			sense_r   <= sense_m_r;
			xclr_m_r  <= ext_clear_in;
			xclr_r    <= xclr_m_r;
			comp_r    <= cmp_raw;
		end
	end

	// =====================================
	// converter samples and bus average
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_r <= 16'h0000;
		end else if (adc_valid && adc_channel == `BP_VBUS_CH) begin
			acc_r <= acc_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (adc_valid) begin
			samp_r[adc_channel] <= adc_data;  // see RL4
		end
	end

	// =====================================
	// duty, timer and commutation
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dcomp_r <= 16'h0000;
			dsh_r   <= 16'h0000;
			cnt_r   <= 16'h0000;
		end else begin
			dcomp_r <= d_clamp;
			if (tmr_clear || wrap) begin
				cnt_r <= 16'h0000;
				dsh_r <= dcomp_r;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scnt_r <= 24'h000000;
			step_r <= BP_S0;
		end else if (!run) begin
			scnt_r <= 24'h000000;
			step_r <= BP_S0;
		end else if (step_tick) begin
			scnt_r <= 24'h000000;
			step_r <= step_nxt;  // see RL3
		end else begin
			scnt_r <= scnt_r + 24'h000001;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			upper_r <= 3'h0;
			lower_r <= 3'h0;
		end else begin
			upper_r <= up_nxt;
			lower_r <= run ? lo_sel : 3'h0;  // see RL2, see RL3
		end
	end

endmodule
`default_nettype wire

/* File: test/bp_top_chk.sv */
// port assertions for the bldc pwm block
`timescale 1ns/10ps
`default_nettype none
module bp_top_chk
	import bp_pkg::*;
(
	input wire logic        clock,                     // system clock
	input wire logic        rst,                       // async reset
	input wire logic        avs_read,                  // read request
	input wire logic        avs_write,                 // write request
	input wire logic [31:0] avs_readdata,              // read data
	input wire logic        avs_waitrequest,           // stall
	input wire logic [9:0]  comparator_input_fourteen, // sense level
	input wire logic [2:0]  upper_gate,                // high-side pwm
	input wire logic [2:0]  lower_gate,                // low-side drive
	input wire logic        comparator_output          // comparator result
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// =====================================
	// sequences
	sequence s_req_wait;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_low_sense;
		(comparator_input_fourteen < 10'h1D1) [*4];
	endsequence
	sequence s_step_hold;
		$stable(lower_gate) [*8];
	endsequence

	// =====================================
	// assertions
	bus_wait_a: assert property (s_req_wait |=> !avs_waitrequest)
		else $error("bus wait state not one cycle");
	idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("stall while idle");
	read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
	upper_one_a: assert property ($onehot0(upper_gate))
		else $error("two upper switches active");
	lower_one_a: assert property ($onehot0(lower_gate))
		else $error("two lower switches on");
	no_shoot_a: assert property ((upper_gate & lower_gate) == 3'h0)
		else $error("leg shoot through");
	upper_pair_a: assert property ((upper_gate != 3'h0) |-> (lower_gate != 3'h0))
		else $error("upper pwm without lower on");
	lower_hold_a: assert property ($changed(lower_gate) |=> s_step_hold)
		else $error("lower switch toggles too fast");
	sense_low_a: assert property (s_low_sense |=> !comparator_output)
		else $error("comparator high below every threshold");
endmodule
`default_nettype wire

/* File: test/bp_inv_model.sv */
// gate driver and current sense amplifier model
`timescale 1ns/10ps
`default_nettype none
module bp_inv_model
	import bp_pkg::*;
(
	input  wire logic       clock,      // system clock
	input  wire logic [2:0] upper_gate, // high-side drive
	input  wire logic [2:0] lower_gate, // low-side drive
	input  wire logic [9:0] current,    // shunt level to present
	output logic [9:0]      sense,      // amplified sense level
	output logic            shoot       // sticky leg short seen
);
	initial shoot = 1'b0;
	always @(posedge clock) begin
		sense <= current;
		shoot <= shoot | (|(upper_gate & lower_gate));
	end
endmodule
`default_nettype wire

/* File: test/bp_top_tb.sv */
// self-checking bench for the bldc pwm block
`timescale 1ns/10ps
`default_nettype none
`include "bp_cfg.svh"
module bp_top_tb
	import bp_pkg::*;
;
	localparam logic [31:0] RUN  = 32'h1 << `BP_RUN_BIT;
	localparam logic [31:0] CPON = 32'h1 << `BP_CPON_BIT;
	localparam logic [31:0] CFEN = 32'h1 << `BP_CFEN_BIT;
	localparam logic [31:0] FEN  = 32'h1 << `BP_FEN_BIT;
	localparam logic [31:0] XCEN = 32'h1 << `BP_XCEN_BIT;
	localparam logic [31:0] ICEN = 32'h1 << `BP_ICEN_BIT;
	logic        clock, rst, avs_read, avs_write, avs_waitrequest;
	logic        adc_valid, ext_clear_in, comparator_output, irq, shoot;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  adc_channel;
	logic [9:0]  adc_data, current, comparator_input_fourteen;
	logic [2:0]  upper_gate, lower_gate;
	int          errors, num_checks;

	bp_top bp_top_i (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .adc_valid(adc_valid), .adc_channel(adc_channel),
		.adc_data(adc_data), .comparator_input_fourteen(comparator_input_fourteen),
		.ext_clear_in(ext_clear_in), .upper_gate(upper_gate), .lower_gate(lower_gate),
		.comparator_output(comparator_output), .irq(irq));
	bp_inv_model bp_inv_model_i (.clock(clock), .upper_gate(upper_gate), .lower_gate(lower_gate),
		.current(current), .sense(comparator_input_fourteen), .shoot(shoot));

	always #2.5 clock = ~clock;

	// =====================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// hold until the edge that sees waitrequest low; only the watchdog ends a hang
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0);
		check(32'(n), 32'h2);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask
	task automatic samp(input logic [3:0] c, input logic [9:0] v);
		@(posedge clock);
		adc_valid <= 1'b1;
		adc_channel <= c;
		adc_data <= v;
		@(posedge clock);
		adc_valid <= 1'b0;
	endtask
	task automatic sense_at(input logic [9:0] v);
		@(posedge clock);
		current <= v;
		repeat (6) @(posedge clock);
		#1;
	endtask
	task automatic pulse(input int n, output logic seen);
		int k;
		k = 0;
		seen = 1'b0;
		@(posedge clock);
		current <= 10'h3FF;
		repeat (n + 16) begin
			@(posedge clock);
			k++;
			if (k == n) current <= 10'h000;
			#1;
			if (upper_gate === 3'h0) seen = 1'b1;
		end
	endtask
	task automatic wait_up(input logic [2:0] e);
		int n;
		n = 0;
		while (upper_gate !== e && n < 800) begin
			@(posedge clock);
			#1;
			n++;
		end
		check({29'h0, upper_gate}, {29'h0, e});
	endtask

	// =====================================
	// scenarios
	task automatic t_reset;
		chk_rd(`BP_CTRL_IDX, 32'h0);
		chk_rd(`BP_PERIOD_IDX, `BP_PERIOD_RST);
		chk_rd(`BP_STEP_IDX, {8'h00, `BP_STEP_RST});
		wr(`BP_STAT_IDX, 32'h7);
		chk_rd(`BP_STAT_IDX, 32'h0);
		chk_rd(5'h0B, 32'h0);
		chk_rd(`BP_IVEC_IDX, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_duty;
		wr(`BP_PERIOD_IDX, 32'h64);
		wr(`BP_DUTY_IDX, 32'h40);
		repeat (1200) samp(`BP_VBUS_CH, 10'h200);
		chk_rd(`BP_VAVG_IDX, 32'h200);
		chk_rd(`BP_DCOMP_IDX, 32'h40);
		samp(`BP_VBUS_CH, 10'h3FF);
		chk_rd(`BP_DCOMP_IDX, 32'h20);
		samp(`BP_VBUS_CH, 10'h000);
		chk_rd(`BP_DCOMP_IDX, 32'h40);
		samp(`BP_VBUS_CH, 10'h001);
		chk_rd(`BP_DCOMP_IDX, 32'h64);
		chk_rd(`BP_SAMP_BASE, 32'h1);
		samp(`BP_SENSE_CH, 10'h155);
		chk_rd(5'h1E, 32'h155);
		$display("duty test done");
	endtask
	task automatic t_comp;
		logic [9:0] rf [4];
		rf = '{`BP_REF_15, `BP_REF_20, `BP_REF_25, `BP_REF_25};
		for (int s = 0; s < 4; s++) begin
			wr(`BP_CTRL_IDX, CPON | (s << `BP_RSEL_LSB));
			sense_at(rf[s] + 10'h001);
			chk1(comparator_output, 1'b1);
			sense_at(rf[s]);
			chk1(comparator_output, 1'b0);
		end
		wr(`BP_CTRL_IDX, 32'h0);
		sense_at(10'h3FF);
		chk1(comparator_output, 1'b0);
		sense_at(10'h000);
		$display("comparator test done");
	endtask
	task automatic t_filter;
		int dly [4];
		logic s;
		dly = '{`BP_FILT0_CYC, `BP_FILT1_CYC, `BP_FILT2_CYC, `BP_FILT3_CYC};
		wr(`BP_STEP_IDX, 32'hFFFFFF);
		for (int i = 0; i < 4; i++) begin
			wr(`BP_CTRL_IDX, RUN | CPON | CFEN | FEN | (i << `BP_FSEL_LSB));
			wait_up(3'h1);
			pulse(dly[i] - 10, s);
			chk1(s, 1'b0);
			pulse(dly[i] + 10, s);
			chk1(s, 1'b1);
		end
		$display("filter test done");
	endtask
	task automatic t_irq;
		logic s;
		wr(`BP_CTRL_IDX, RUN | CPON | FEN | XCEN);
		wr(`BP_ICLR_IDX, 32'h7);
		wr(`BP_IEN_IDX, 32'h3);
		chk1(irq, 1'b0);
		wait_up(3'h1);
		pulse(4, s);
		chk1(s, 1'b1);
		wait_up(3'h1);
		chk1(irq, 1'b1);
		@(posedge clock);
		ext_clear_in <= 1'b1;
		repeat (4) @(posedge clock);
		ext_clear_in <= 1'b0;
		chk_rd(`BP_STAT_IDX, 32'h3);
		chk_rd(`BP_IVEC_IDX, {28'h0, BP_IV_FAULT});
		wr(`BP_ICLR_IDX, 32'h1);
		chk_rd(`BP_IVEC_IDX, {28'h0, BP_IV_XCLR});
		wr(`BP_ICLR_IDX, 32'h2);
		chk_rd(`BP_STAT_IDX, 32'h0);
		chk1(irq, 1'b0);
		wr(`BP_IEN_IDX, 32'h0);
		pulse(4, s);
		chk_rd(`BP_STAT_IDX, 32'h1);
		chk1(irq, 1'b0);
		wr(`BP_ICLR_IDX, 32'h1);
		$display("interrupt test done");
	endtask
	task automatic t_step;
		logic [2:0] up [6];
		logic [2:0] lo [6];
		up = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
		lo = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
		wr(`BP_CTRL_IDX, 32'h0);
		wr(`BP_STEP_IDX, 32'hC8);
		repeat (12) @(posedge clock);
		#1;
		check({26'h0, upper_gate, lower_gate}, 32'h0);
		wr(`BP_CTRL_IDX, RUN | ICEN);
		for (int i = 0; i < 6; i++) begin
			repeat (100) @(posedge clock);
			#1;
			check({26'h0, upper_gate, lower_gate}, {26'h0, up[i], lo[i]});
			repeat (100) @(posedge clock);
		end
		wr(`BP_IEN_IDX, 32'h4);
		chk_rd(`BP_IVEC_IDX, {28'h0, BP_IV_ICLR});
		$display("commutation test done");
	endtask

	// =====================================
	// run control
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		wrap_up;
	end
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		adc_valid = 1'b0;
		adc_channel = 4'h0;
		adc_data = 10'h000;
		ext_clear_in = 1'b0;
		current = 10'h000;
		errors = 0;
		num_checks = 0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_duty;
		t_comp;
		t_filter;
		t_irq;
		t_step;
		chk1(shoot, 1'b0);
		wrap_up;
	end
endmodule
bind bp_top bp_top_chk bp_top_chk_i (.clock(clock), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.comparator_input_fourteen(comparator_input_fourteen), .upper_gate(upper_gate),
	.lower_gate(lower_gate), .comparator_output(comparator_output));
`default_nettype wire
